// [inc/lsr_pkg.sv]
// constants for the light sensor register block: command codes, field
// positions, reset values and measurement timing.
// assumes a 16-bit word interface in front of the block, run off one clock.
package lsr_pkg;

  // command codes of the register words
  localparam logic [2:0] CODE_CONFIG = 3'h0;
  localparam logic [2:0] CODE_UPPER = 3'h1;
  localparam logic [2:0] CODE_LOWER = 3'h2;
  localparam logic [2:0] CODE_SAVING = 3'h3;
  localparam logic [2:0] CODE_LIGHT = 3'h4;
  localparam logic [2:0] CODE_WHITE = 3'h5;
  localparam logic [2:0] CODE_STATUS = 3'h6;

  // reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0001;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // configuration word fields
  localparam int GAIN_LSB = 11;
  localparam int ITIME_LSB = 6;
  localparam int PERS_LSB = 4;
  localparam int IRQ_EN_BIT = 1;
  localparam int SHUTDOWN_BIT = 0;

  // power saving word fields
  localparam int SAVE_MODE_LSB = 1;
  localparam int SAVE_EN_BIT = 0;

  // status word fields
  localparam int BELOW_BIT = 15;
  localparam int ABOVE_BIT = 14;

  // integration period encodings and their lengths in ms
  localparam logic [3:0] ITIME_25 = 4'hc;
  localparam logic [3:0] ITIME_50 = 4'h8;
  localparam logic [3:0] ITIME_100 = 4'h0;
  localparam logic [3:0] ITIME_200 = 4'h1;
  localparam logic [3:0] ITIME_400 = 4'h2;
  localparam logic [3:0] ITIME_800 = 4'h3;
  localparam logic [12:0] MS_25 = 13'h0019;
  localparam logic [12:0] MS_50 = 13'h0032;
  localparam logic [12:0] MS_100 = 13'h0064;
  localparam logic [12:0] MS_200 = 13'h00c8;
  localparam logic [12:0] MS_400 = 13'h0190;
  localparam logic [12:0] MS_800 = 13'h0320;

  // extra wait in mode 0, doubled for each further mode
  localparam logic [12:0] SAVE_BASE_MS = 13'h01f4;

  // clock rate and length of one timer tick
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 1;
  localparam int CYCLES_PER_TICK = CLK_HZ / 1000 * TICK_MS;

endpackage

// [hw/lsr_ms_timer.sv]
// millisecond divider and period counter for the measurement sequencer.
// assumes load is a one-cycle pulse; a new load restarts the period.
`timescale 1ns/10ps
module lsr_ms_timer
  import lsr_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYCLES_PER_TICK
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // period control
  input wire logic load,
  input wire logic [12:0] load_ms,
  input wire logic halt,
  // end of period, one cycle
  output logic done
);

  logic [15:0] div_count; // cycles within the current ms
  logic ms_tick; // one-cycle enable each ms
  logic [12:0] ms_left; // ms still to run
  logic running; // a period is in progress

  assign ms_tick = running && (div_count == 16'(CYCLES_PER_MS - 1));

  // ms divider, restarted on each load so periods are exact
  always_ff @(posedge ref_clk) begin
    if (rst || load || halt || ms_tick) begin
      div_count <= 16'h0000;
    end else if (running) begin
      div_count <= div_count + 16'h0001;
    end
  end

  // period countdown
  always_ff @(posedge ref_clk) begin
    if (rst || halt) begin
      ms_left <= 13'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      ms_left <= load_ms;
      running <= (load_ms != 13'h0000);
      done <= 1'b0;
    end else if (ms_tick) begin
      ms_left <= ms_left - 13'h0001;
      // last ms ends the period
      running <= (ms_left != 13'h0001);
      done <= (ms_left == 13'h0001);
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// [hw/lsr_regs.sv]
// register words and measurement control of the ambient light sensor.
// assumes a serial bus engine outside that turns each word transfer into
// one read or write pulse with a command code, and an analog front end
// whose converted results are valid on adc_light and adc_white.
`timescale 1ns/10ps
module lsr_regs
  import lsr_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYCLES_PER_TICK
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // word access from the serial bus engine
  input wire logic [2:0] reg_sel,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // analog front end
  input wire logic [15:0] adc_light,
  input wire logic [15:0] adc_white,
  output logic afe_power_on,
  output logic afe_integrate,
  output logic [1:0] light_gain_select,
  // interrupt pin, open drain, active low
  output logic irq_n_out,
  output logic irq_n_oe
);

  // register words
  logic [15:0] measure_config; // code 0
  logic [15:0] upper_window_limit; // code 1
  logic [15:0] lower_window_limit; // code 2
  logic [15:0] power_saving_control; // code 3
  logic [15:0] light_result; // code 4
  logic [15:0] white_result; // code 5
  logic below_window_flag; // status bit 15
  logic above_window_flag; // status bit 14

  // decoded fields
  logic [3:0] integration_period;
  logic [1:0] trigger_persistence;
  logic threshold_irq_enable;
  logic sensor_shutdown;
  logic [1:0] saving_mode_select;
  logic saving_mode_enable;

  // sequencer
  typedef enum logic [1:0] {st_idle, st_integ, st_save} lsr_state_type;
  lsr_state_type state;
  logic timer_load; // start a period
  logic [12:0] timer_ms; // its length
  logic timer_done; // period over
  logic meas_end; // integration finished this cycle
  logic is_below; // sample under the window
  logic is_above; // sample over the window
  logic [3:0] run_count; // consecutive samples outside
  logic [3:0] next_run_count;
  logic [3:0] pers_needed; // samples needed before a flag
  logic status_read; // host reads the status word

  // integration period in ms; unlisted codes run as 100 ms
  function automatic logic [12:0] lsr_itime_ms(input logic [3:0] code);
    unique case (code)
      ITIME_25: lsr_itime_ms = MS_25;
      ITIME_50: lsr_itime_ms = MS_50;
      ITIME_100: lsr_itime_ms = MS_100;
      ITIME_200: lsr_itime_ms = MS_200;
      ITIME_400: lsr_itime_ms = MS_400;
      ITIME_800: lsr_itime_ms = MS_800;
      default: lsr_itime_ms = MS_100;
    endcase
  endfunction

  // samples required: 1, 2, 4 or 8
  function automatic logic [3:0] lsr_pers_count(input logic [1:0] code);
    lsr_pers_count = 4'h1 << code;
  endfunction

  // extra saving wait: 500 ms doubled per mode step
  function automatic logic [12:0] lsr_save_ms(input logic [1:0] mode);
    lsr_save_ms = SAVE_BASE_MS << mode;
  endfunction

  // field decode
  assign light_gain_select = measure_config[GAIN_LSB +: 2];
  assign integration_period = measure_config[ITIME_LSB +: 4];
  assign trigger_persistence = measure_config[PERS_LSB +: 2];
  assign threshold_irq_enable = measure_config[IRQ_EN_BIT];
  assign sensor_shutdown = measure_config[SHUTDOWN_BIT];
  assign saving_mode_select = power_saving_control[SAVE_MODE_LSB +: 2];
  assign saving_mode_enable = power_saving_control[SAVE_EN_BIT];
  assign pers_needed = lsr_pers_count(trigger_persistence);
  assign meas_end = (state == st_integ) && timer_done;
  assign is_below = adc_light < lower_window_limit;
  assign is_above = adc_light > upper_window_limit;
  assign status_read = reg_read && (reg_sel == CODE_STATUS);

  // config word; reserved bits stored as written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      measure_config <= CONFIG_RESET;
    end else if (reg_write && reg_sel == CODE_CONFIG) begin
      measure_config <= reg_wdata;
    end
  end

  // threshold and saving words
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      upper_window_limit <= WORD_RESET;
      lower_window_limit <= WORD_RESET;
      power_saving_control <= WORD_RESET;
    end else if (reg_write) begin
      // read-only and unmapped codes ignore writes
      if (reg_sel == CODE_UPPER) begin
        upper_window_limit <= reg_wdata;
      end
      if (reg_sel == CODE_LOWER) begin
        lower_window_limit <= reg_wdata;
      end
      if (reg_sel == CODE_SAVING) begin
        power_saving_control <= reg_wdata;
      end
    end
  end

  // word read by command code, one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= WORD_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        unique case (reg_sel)
          CODE_CONFIG: reg_rdata <= measure_config;
          CODE_UPPER: reg_rdata <= upper_window_limit;
          CODE_LOWER: reg_rdata <= lower_window_limit;
          CODE_SAVING: reg_rdata <= power_saving_control;
          CODE_LIGHT: reg_rdata <= light_result;
          CODE_WHITE: reg_rdata <= white_result;
          CODE_STATUS: reg_rdata <= {below_window_flag, above_window_flag, 14'h0000};
          default: reg_rdata <= WORD_RESET;
        endcase
      end
    end
  end

  // measurement sequence: integrate, then optional saving wait
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= st_idle;
    end else if (sensor_shutdown) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: state <= st_integ;
        st_integ: begin
          if (timer_done) begin
            state <= saving_mode_enable ? st_save : st_integ;
          end
        end
        st_save: begin
          if (timer_done) begin
            state <= st_integ;
          end
        end
      endcase
    end
  end

  // period start and length for the timer
  always_comb begin
    timer_load = 1'b0;
    timer_ms = lsr_itime_ms(integration_period);
    if (!sensor_shutdown) begin
      unique case (state)
        st_idle: timer_load = 1'b1;
        st_integ: begin
          if (timer_done) begin
            timer_load = 1'b1;
            if (saving_mode_enable) begin
              timer_ms = lsr_save_ms(saving_mode_select);
            end
          end
        end
        st_save: timer_load = timer_done;
      endcase
    end
  end

  lsr_ms_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) i_lsr_ms_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(timer_load),
    .load_ms(timer_ms),
    .halt(sensor_shutdown),
    .done(timer_done)
  );

  // results: taken at each integration end, held in shutdown
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      light_result <= WORD_RESET;
      white_result <= WORD_RESET;
    end else if (meas_end) begin
      light_result <= adc_light;
      white_result <= adc_white;
    end
  end

  // consecutive out-of-window count, saturating at eight
  always_comb begin
    next_run_count = run_count;
    if (meas_end) begin
      if (!(is_below || is_above)) begin
        next_run_count = 4'h0;
      end else if (run_count < 4'h8) begin
        next_run_count = run_count + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_count <= 4'h0;
    end else begin
      run_count <= next_run_count;
    end
  end

  // status flags: set by events, cleared by reading, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      below_window_flag <= 1'b0;
      above_window_flag <= 1'b0;
    end else begin
      if (meas_end && threshold_irq_enable && is_below && next_run_count >= pers_needed) begin
        below_window_flag <= 1'b1;
      end else if (status_read) begin
        below_window_flag <= 1'b0;
      end
      if (meas_end && threshold_irq_enable && is_above && next_run_count >= pers_needed) begin
        above_window_flag <= 1'b1;
      end else if (status_read) begin
        above_window_flag <= 1'b0;
      end
    end
  end

  // front end controls and interrupt pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      afe_power_on <= 1'b0;
      afe_integrate <= 1'b0;
      irq_n_oe <= 1'b0;
    end else begin
      afe_power_on <= !sensor_shutdown;
      afe_integrate <= (state == st_integ) && !sensor_shutdown;
      irq_n_oe <= threshold_irq_enable && (below_window_flag || above_window_flag);
    end
  end

  // open drain only ever pulls low
  always_ff @(posedge ref_clk) begin
    irq_n_out <= 1'b0;
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_config_reset: assert property ($fell(rst) |-> measure_config == CONFIG_RESET)
    else $error("config word not at reset value");
  a_power_follows: assert property (##1 afe_power_on == !$past(sensor_shutdown))
    else $error("power output does not follow shutdown bit");
  a_irq_gated: assert property ($rose(above_window_flag) |-> $past(threshold_irq_enable))
    else $error("flag raised with interrupt disabled");
  a_persist_count: assert property ($rose(below_window_flag) |->
      $past(next_run_count) >= $past(pers_needed) && $past(meas_end))
    else $error("flag raised before persistence count");
  a_result_hold: assert property (!meas_end |=> $stable(light_result))
    else $error("result changed outside integration end");
  a_result_load: assert property (meas_end |=> light_result == $past(adc_light)
      && white_result == $past(adc_white))
    else $error("result not loaded at integration end");
  a_upper_read: assert property (reg_read && reg_sel == CODE_UPPER |=>
      reg_rvalid && reg_rdata == $past(upper_window_limit))
    else $error("upper word read back wrong");
  a_light_ro: assert property (reg_write && reg_sel == CODE_LIGHT && !meas_end |=>
      $stable(light_result))
    else $error("light result written by host");
  a_save_entry: assert property (meas_end && saving_mode_enable && !sensor_shutdown |=>
      state == st_save)
    else $error("saving wait not entered");
  a_status_clear: assert property (status_read && !meas_end |=>
      !below_window_flag && !above_window_flag)
    else $error("status flags not cleared by read");
  a_gain_field: assert property (reg_write && reg_sel == CODE_CONFIG |=>
      light_gain_select == $past(reg_wdata[GAIN_LSB +: 2]))
    else $error("gain select off its field");

endmodule

// [testbench/lsr_host.sv]
// host model: issues single word reads and writes on the register port.
// assumes the block answers a read with reg_rvalid one cycle later.
`timescale 1ns/10ps
module lsr_host (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [2:0] reg_sel,
  output logic reg_write,
  output logic reg_read,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus at time zero
  initial begin
    reg_sel = 3'h7;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 16'h0000;
  end

  // one word write, reserved bits forced to zero
  task automatic wr(input logic [2:0] c, input logic [15:0] d);
    @(negedge ref_clk);
    reg_sel = c;
    reg_wdata = (c == 3'h0) ? (d & 16'h1bf3) : (c == 3'h3) ? (d & 16'h0007) : d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    reg_wdata = ~reg_wdata; // stale data once released
  endtask

  // one word read, data taken in the valid cycle
  task automatic rd(input logic [2:0] c, output logic [15:0] d);
    @(negedge ref_clk);
    reg_sel = c;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hbad0;
  endtask
endmodule

// [testbench/light_sensor_register_map_bench.sv]
// self-checking bench for the light sensor register block.
// assumes the front end results are steady while the bench holds them.
`timescale 1ns/10ps
module light_sensor_register_map_bench;
  import lsr_pkg::*;
  // short millisecond keeps the run brief
  localparam int CPM = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_sel;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic [15:0] adc_light = 16'h0000;
  logic [15:0] adc_white = 16'h0000;
  logic afe_power_on;
  logic afe_integrate;
  logic [1:0] light_gain_select;
  logic irq_n_out;
  logic irq_n_oe;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;

  // clock and cycle count
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) cyc <= cyc + 1;

  lsr_regs #(.CYCLES_PER_MS(CPM)) i_lsr_regs (.ref_clk(ref_clk), .rst(rst),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .adc_light(adc_light), .adc_white(adc_white), .afe_power_on(afe_power_on),
    .afe_integrate(afe_integrate), .light_gain_select(light_gain_select),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  lsr_host i_lsr_host (.ref_clk(ref_clk), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // read a word and compare it
  task automatic rdchk(input logic [2:0] c, input logic [15:0] exp);
    logic [15:0] d;
    i_lsr_host.rd(c, d);
    chk(d, exp);
  endtask

  // wait for a cycle count
  task automatic wait_to(input int t);
    while (cyc < t) @(negedge ref_clk);
  endtask

  // shutdown then power on, so the measurement phase is known
  task automatic start_on(input logic [15:0] cfg);
    i_lsr_host.wr(CODE_CONFIG, cfg | 16'h0001);
    i_lsr_host.wr(CODE_CONFIG, cfg);
    t0 = cyc;
  endtask

  // reset values
  task automatic t_reset();
    rdchk(CODE_CONFIG, CONFIG_RESET);
    rdchk(CODE_UPPER, WORD_RESET);
    rdchk(CODE_LOWER, WORD_RESET);
    rdchk(CODE_SAVING, WORD_RESET);
    chk({13'h0, afe_power_on, afe_integrate, irq_n_oe}, 16'h0000);
  endtask

  // writable words and read-only results
  task automatic t_words();
    i_lsr_host.wr(CODE_UPPER, 16'ha55a);
    i_lsr_host.wr(CODE_LOWER, 16'h5aa5);
    i_lsr_host.wr(CODE_LIGHT, 16'hffff);
    i_lsr_host.wr(CODE_WHITE, 16'hffff);
    rdchk(CODE_UPPER, 16'ha55a);
    rdchk(CODE_LOWER, 16'h5aa5);
    rdchk(CODE_LIGHT, WORD_RESET);
    rdchk(CODE_WHITE, WORD_RESET);
    rdchk(3'h7, WORD_RESET);
    for (int m = 0; m < 8; m++) begin
      i_lsr_host.wr(CODE_SAVING, 16'(m));
      rdchk(CODE_SAVING, 16'(m));
    end
    i_lsr_host.wr(CODE_SAVING, 16'h0000);
  endtask

  // every gain code reaches the front end
  task automatic t_gain();
    for (int g = 0; g < 4; g++) begin
      i_lsr_host.wr(CODE_CONFIG, 16'h0001 | 16'(g << GAIN_LSB));
      chk({14'h0, light_gain_select}, 16'(g));
      rdchk(CODE_CONFIG, 16'h0001 | 16'(g << GAIN_LSB));
    end
  endtask

  // power on, results, shutdown keeps them
  task automatic t_power();
    adc_light = 16'h00ff;
    adc_white = 16'h4321;
    start_on(16'h0300);
    wait_to(t0 + 2);
    chk({14'h0, afe_power_on, afe_integrate}, 16'h0003);
    wait_to(t0 + 110);
    rdchk(CODE_LIGHT, 16'h00ff);
    rdchk(CODE_WHITE, 16'h4321);
    i_lsr_host.wr(CODE_CONFIG, 16'h0301);
    adc_white = 16'h0bad;
    wait_to(cyc + 300);
    chk({14'h0, afe_power_on, afe_integrate}, 16'h0000);
    rdchk(CODE_WHITE, 16'h4321);
  endtask

  // every integration period, seen through the result timing
  task automatic t_itime();
    // last entry is an unlisted code, which runs as 100 ms
    logic [3:0] code [7] = '{ITIME_25, ITIME_50, ITIME_100, ITIME_200, ITIME_400,
      ITIME_800, 4'h5};
    int ms [7] = '{25, 50, 100, 200, 400, 800, 100};
    for (int i = 0; i < 7; i++) begin
      adc_light = 16'h0100 + 16'(i);
      start_on(16'(code[i]) << ITIME_LSB);
      wait_to(t0 + ms[i] * CPM - 4);
      rdchk(CODE_LIGHT, 16'h00ff + 16'(i));
      wait_to(t0 + ms[i] * CPM + 8);
      rdchk(CODE_LIGHT, 16'h0100 + 16'(i));
    end
  endtask

  // window flags, enable and every persistence count
  task automatic t_irq();
    i_lsr_host.wr(CODE_UPPER, 16'h1000);
    i_lsr_host.wr(CODE_LOWER, 16'h0100);
    adc_light = 16'h0010;
    start_on(16'h0300);
    wait_to(t0 + 110);
    chk({15'h0, irq_n_oe}, 16'h0000);
    rdchk(CODE_STATUS, 16'h0000);
    adc_light = 16'h2000;
    start_on(16'h0302);
    wait_to(t0 + 110);
    chk({14'h0, irq_n_oe, irq_n_out}, 16'h0002);
    rdchk(CODE_STATUS, 16'h4000);
    wait_to(cyc + 2);
    chk({14'h0, irq_n_oe, irq_n_out}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      adc_light = 16'h0800;
      start_on(16'h0302 | 16'(k << PERS_LSB));
      wait_to(t0 + 110);
      rdchk(CODE_STATUS, 16'h0000);
      adc_light = 16'h0010;
      start_on(16'h0302 | 16'(k << PERS_LSB));
      wait_to(t0 + (1 << k) * 100 - 70);
      rdchk(CODE_STATUS, 16'h0000);
      wait_to(t0 + (1 << k) * 100 + 30);
      rdchk(CODE_STATUS, 16'h8000);
    end
  endtask

  // every saving mode stretches the refresh period
  task automatic t_save();
    for (int m = 0; m < 4; m++) begin
      i_lsr_host.wr(CODE_SAVING, 16'(m << SAVE_MODE_LSB) | 16'h0001);
      adc_light = 16'h0a00 + 16'(m);
      start_on(16'h0300);
      wait_to(t0 + 110);
      rdchk(CODE_LIGHT, 16'h0a00 + 16'(m));
      adc_light = 16'h0b00 + 16'(m);
      wait_to(t0 + 200 + (2000 << m) - 20);
      rdchk(CODE_LIGHT, 16'h0a00 + 16'(m));
      wait_to(t0 + 200 + (2000 << m) + 20);
      rdchk(CODE_LIGHT, 16'h0b00 + 16'(m));
    end
    i_lsr_host.wr(CODE_SAVING, 16'h0000);
  endtask

  // verdict and end of run
  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_words();
    t_gain();
    t_power();
    t_itime();
    t_irq();
    t_save();
    results();
  end

  // watchdog, about twice the expected run
  initial begin
    #4000000;
    bad_count++;
    results();
  end
endmodule
